// *** lrjd_map.vh ***
// Constants for the load and relative jump decoder: opcodes, operand
// codes, register indices and reset values.
// Assumes inclusion by bare name from every lrjd design file.
`ifndef LRJD_MAP_VH
`define LRJD_MAP_VH

// ----------------------------------------------------------------------
// First-byte opcodes
// ----------------------------------------------------------------------
`define LRJD_OP_LDA_IMM_HI 4'hb
`define LRJD_OP_LDA_DIR 8'h8c
`define LRJD_OP_STA_DIR 8'h89
`define LRJD_OP_IND_HI 5'h11
`define LRJD_OP_PIMM_HI 5'h10
`define LRJD_PFX_REG 8'hdd
`define LRJD_PFX_IMM 8'hd9
`define LRJD_PFX_PAIR 8'hdc
`define LRJD_OP_LDP_DIR 8'hce
`define LRJD_OP_STP_DIR 8'hcd
`define LRJD_OP_STA_PTR 8'hc4
`define LRJD_JR_HI 3'h0
`define LRJD_NOP 8'h00

// ----------------------------------------------------------------------
// Second-byte codes
// ----------------------------------------------------------------------
`define LRJD_B2_LDP_PTR 8'h08
`define LRJD_B2_STP_PTR 8'h00
`define LRJD_B2_JR_IDX 8'h64
`define LRJD_B2_JR_ACC 8'h60
`define LRJD_B2_MOV_HI 4'h0
`define LRJD_B2_EA_FROM 5'h1f
`define LRJD_B2_EA_TO 5'h1e

// ----------------------------------------------------------------------
// Register codes; nibble index = code, pair p holds {2p+1, 2p}
// ----------------------------------------------------------------------
`define LRJD_R_ACC 3'h0
`define LRJD_R_EXT 3'h1
`define LRJD_R_PLO 3'h2
`define LRJD_R_XLO 3'h4
`define LRJD_R_XHI 3'h5
`define LRJD_P_ACC 2'h0
`define LRJD_P_PTR 2'h1
`define LRJD_I_PTR 3'h5
`define LRJD_I_IDX 3'h6
`define LRJD_I_MIX 3'h7

// ----------------------------------------------------------------------
// Reset values and address steps
// ----------------------------------------------------------------------
`define LRJD_NIB_RST 4'h0
`define LRJD_PC_RST 14'h0000
`define LRJD_BYTE_RST 8'h00
`define LRJD_PC_ONE 14'h0001
`define LRJD_PC_NEXT2 14'h0002

`endif

// *** lrjd_regfile.v ***
// Nibble register file: accumulator, extension and six pair halves.
// Assumes a single clock; two write ports that never hit one index.
`timescale 1ns/100ps
`include "lrjd_map.vh"

module lrjd_regfile #(
  parameter NREG = 8
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_we0,
  input wire [2:0] i_idx0,
  input wire [3:0] i_data0,
  input wire i_we1,
  input wire [2:0] i_idx1,
  input wire [3:0] i_data1,
  output wire [4*NREG-1:0] o_flat
);

  // --------------------------------------------------------------------
  // One flop group per nibble
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_nib
      reg [3:0] nib;
      always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          nib <= `LRJD_NIB_RST;
        end else if (i_we0 && i_idx0 == g) begin
          nib <= i_data0;
        end else if (i_we1 && i_idx1 == g) begin
          nib <= i_data1;
        end
      end
      assign o_flat[4*g+3:4*g] = nib;
    end
  endgenerate

endmodule // lrjd_regfile

// *** lrjd_jump.v ***
// Relative jump target former for the short immediate and the
// register-relative forms. Purely combinational.
// Assumes i_pc is the address of the jump's first byte.
`timescale 1ns/100ps
`include "lrjd_map.vh"

module lrjd_jump (
  input wire [13:0] i_pc,
  input wire i_imm_form,
  input wire [7:0] i_first,
  input wire [7:0] i_low,
  output reg [13:0] o_target
);

  reg [13:0] step;
  reg [13:0] page;

  always @* begin
    step = {10'h000, i_first[3:0]};
    page = i_pc + `LRJD_PC_NEXT2;
    if (i_imm_form) begin
      // Forward form covers +1..+16, backward form -1..-15
      if (i_first[4]) begin
        o_target = i_pc + `LRJD_PC_ONE + step;
      end else begin
        o_target = i_pc - step;
      end
    end else begin
      // Page from the address after the two-byte code
      o_target = {page[13:8], i_low};
    end
  end

endmodule // lrjd_jump

// *** lrjd_decode.v ***
// Decode and execute of the nibble load family and relative jumps.
// Assumes a byte fetch stream with the byte's own address, and a data
// memory whose read data answers the address in the same cycle.
//
// Overview of operation
// - Immediate to accumulator, one byte, one cycle.
// - Indirect nibble load to accumulator, one cycle.
// - Direct memory to accumulator, two bytes, two cycles.
// - Register to/from accumulator via prefix, two cycles.
// - Immediate to nibble register via prefix, two cycles.
// - Eight-bit immediate loads selected pair, two cycles.
// - Accumulator to direct memory, two cycles.
// - Pair load through pointer pair, two cycles.
// - Pair store through pointer pair, two cycles.
// - Direct pair load/store, extension at address plus one.
// - Pair to/from accumulator pair, high to extension.
// - Accumulator store through pointer pair, one cycle.
// - Loads never change the source.
// - Repeated accumulator/pointer immediate loads become no-ops.
// - Other pair immediate loads always execute.
// - Register jump keeps high PC, replaces low byte.
// - Short jump spans minus 15 to plus 16.
// - Register code selects one of eight nibbles.
// - Pointer pair transfers force address bit zero low.
// - First byte at page end uses next page.
`timescale 1ns/100ps
`include "lrjd_map.vh"

module lrjd_decode (
  input wire i_clk,
  input wire i_rst,
  input wire i_fetch_valid,
  input wire [7:0] i_fetch_byte,
  input wire [13:0] i_fetch_pc,
  output wire o_fetch_ready,
  output wire [7:0] o_mem_addr,
  output wire o_mem_rd,
  output wire o_mem_wr,
  output wire o_mem_pair,
  output wire [7:0] o_mem_wdata,
  input wire [7:0] i_mem_rdata,
  output reg o_jump,
  output reg [13:0] o_jump_target,
  output reg o_suppressed,
  output wire [31:0] o_regs
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam S_OP = 2'h0;
  localparam S_OPND = 2'h1;
  localparam S_WAIT = 2'h2;

  reg [1:0] state;
  reg [7:0] op;
  reg [13:0] op_pc;
  reg sup;
  reg grp_acc;
  reg grp_ptr;

  reg [1:0] next_state;
  reg next_grp_acc;
  reg next_grp_ptr;
  reg next_sup;
  reg next_jump;
  reg next_imm_form;
  reg [7:0] next_low;
  reg next_suppressed;
  reg we0;
  reg [2:0] idx0;
  reg [3:0] d0;
  reg we1;
  reg [2:0] idx1;
  reg [3:0] d1;
  reg mem_rd;
  reg mem_wr;
  reg mem_pair;
  reg [7:0] mem_addr;
  reg [7:0] mem_wdata;

  wire take;
  wire [7:0] b;
  wire [3:0] rn [0:7];
  wire [13:0] target;
  wire [7:0] ptr_addr;

  assign take = i_fetch_valid && o_fetch_ready;
  assign b = i_fetch_byte;
  assign o_fetch_ready = (state != S_WAIT);

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rn
      assign rn[g] = o_regs[4*g+3:4*g];
    end
  endgenerate

  // Register bit zero stays untouched; only the address is forced even
  assign ptr_addr = {rn[`LRJD_R_PLO + 3'h1], rn[`LRJD_R_PLO][3:1], 1'b0};

  // --------------------------------------------------------------------
  // Decode and execute
  // --------------------------------------------------------------------
  always @* begin
    next_state = state;
    next_grp_acc = grp_acc;
    next_grp_ptr = grp_ptr;
    next_sup = sup;
    next_jump = 1'b0;
    next_imm_form = 1'b0;
    next_low = `LRJD_BYTE_RST;
    next_suppressed = 1'b0;
    we0 = 1'b0;
    idx0 = `LRJD_R_ACC;
    d0 = `LRJD_NIB_RST;
    we1 = 1'b0;
    idx1 = `LRJD_R_EXT;
    d1 = `LRJD_NIB_RST;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_pair = 1'b0;
    mem_addr = `LRJD_BYTE_RST;
    mem_wdata = `LRJD_BYTE_RST;
    case (state)
      S_OP: begin
        if (take) begin
          next_grp_acc = 1'b0;
          next_grp_ptr = 1'b0;
          next_sup = 1'b0;
          if (b[7:4] == `LRJD_OP_LDA_IMM_HI) begin
            next_grp_acc = 1'b1;
            if (grp_acc) begin
              next_suppressed = 1'b1;
            end else begin
              we0 = 1'b1;
              idx0 = `LRJD_R_ACC;
              d0 = b[3:0];
            end
          end else if (b == `LRJD_OP_LDA_DIR || b == `LRJD_OP_STA_DIR) begin
            next_state = S_OPND;
          end else if (b[7:3] == `LRJD_OP_IND_HI) begin
            if (b[2:0] == `LRJD_I_PTR || b[2:0] == `LRJD_I_IDX ||
                b[2:0] == `LRJD_I_MIX) begin
              mem_rd = 1'b1;
              if (b[2:0] == `LRJD_I_PTR) begin
                mem_addr = {rn[`LRJD_R_PLO + 3'h1], rn[`LRJD_R_PLO]};
              end else if (b[2:0] == `LRJD_I_IDX) begin
                mem_addr = {rn[`LRJD_R_XHI], rn[`LRJD_R_XLO]};
              end else begin
                mem_addr = {rn[`LRJD_R_XHI], rn[`LRJD_R_PLO]};
              end
              we0 = 1'b1;
              idx0 = `LRJD_R_ACC;
              d0 = i_mem_rdata[3:0];
            end
          end else if (b[7:3] == `LRJD_OP_PIMM_HI && b[0]) begin
            next_state = S_OPND;
            if (b[2:1] == `LRJD_P_ACC) begin
              next_grp_acc = 1'b1;
              next_sup = grp_acc;
            end else if (b[2:1] == `LRJD_P_PTR) begin
              next_grp_ptr = 1'b1;
              next_sup = grp_ptr;
            end
          end else if (b == `LRJD_PFX_REG || b == `LRJD_PFX_IMM ||
                       b == `LRJD_PFX_PAIR || b == `LRJD_OP_LDP_DIR ||
                       b == `LRJD_OP_STP_DIR) begin
            next_state = S_OPND;
          end else if (b == `LRJD_OP_STA_PTR) begin
            mem_wr = 1'b1;
            mem_addr = {rn[`LRJD_R_PLO + 3'h1], rn[`LRJD_R_PLO]};
            mem_wdata = {4'h0, rn[`LRJD_R_ACC]};
          end else if (b[7:5] == `LRJD_JR_HI && b != `LRJD_NOP) begin
            next_jump = 1'b1;
            next_imm_form = 1'b1;
            next_state = S_WAIT;
          end
        end
      end
      S_OPND: begin
        if (take) begin
          next_state = S_OP;
          if (op == `LRJD_OP_LDA_DIR) begin
            mem_rd = 1'b1;
            mem_addr = b;
            we0 = 1'b1;
            d0 = i_mem_rdata[3:0];
          end else if (op == `LRJD_OP_STA_DIR) begin
            mem_wr = 1'b1;
            mem_addr = b;
            mem_wdata = {4'h0, rn[`LRJD_R_ACC]};
          end else if (op[7:3] == `LRJD_OP_PIMM_HI) begin
            if (sup) begin
              next_suppressed = 1'b1;
            end else begin
              we0 = 1'b1;
              idx0 = {op[2:1], 1'b0};
              d0 = b[3:0];
              we1 = 1'b1;
              idx1 = {op[2:1], 1'b1};
              d1 = b[7:4];
            end
          end else if (op == `LRJD_PFX_REG) begin
            if (b == `LRJD_B2_JR_IDX || b == `LRJD_B2_JR_ACC) begin
              next_jump = 1'b1;
              next_low = (b == `LRJD_B2_JR_IDX) ?
                         {rn[`LRJD_R_XHI], rn[`LRJD_R_XLO]} :
                         {rn[`LRJD_R_EXT], rn[`LRJD_R_ACC]};
              next_state = S_WAIT;
            end else if (b[7:4] == `LRJD_B2_MOV_HI && b[3]) begin
              we0 = 1'b1;
              d0 = rn[b[2:0]];
            end else if (b[7:4] == `LRJD_B2_MOV_HI) begin
              we0 = 1'b1;
              idx0 = b[2:0];
              d0 = rn[`LRJD_R_ACC];
            end
          end else if (op == `LRJD_PFX_IMM) begin
            if (b[3]) begin
              we0 = 1'b1;
              idx0 = b[2:0];
              d0 = b[7:4];
            end
          end else if (op == `LRJD_PFX_PAIR) begin
            if (b == `LRJD_B2_LDP_PTR) begin
              mem_rd = 1'b1;
              mem_pair = 1'b1;
              mem_addr = ptr_addr;
              we0 = 1'b1;
              d0 = i_mem_rdata[3:0];
              we1 = 1'b1;
              d1 = i_mem_rdata[7:4];
            end else if (b == `LRJD_B2_STP_PTR) begin
              mem_wr = 1'b1;
              mem_pair = 1'b1;
              mem_addr = ptr_addr;
              mem_wdata = {rn[`LRJD_R_EXT], rn[`LRJD_R_ACC]};
            end else if (b[7:3] == `LRJD_B2_EA_FROM && !b[0]) begin
              we0 = 1'b1;
              d0 = rn[{b[2:1], 1'b0}];
              we1 = 1'b1;
              d1 = rn[{b[2:1], 1'b1}];
            end else if (b[7:3] == `LRJD_B2_EA_TO && !b[0]) begin
              we0 = 1'b1;
              idx0 = {b[2:1], 1'b0};
              d0 = rn[`LRJD_R_ACC];
              we1 = 1'b1;
              idx1 = {b[2:1], 1'b1};
              d1 = rn[`LRJD_R_EXT];
            end
          end else if (op == `LRJD_OP_LDP_DIR) begin
            mem_rd = 1'b1;
            mem_pair = 1'b1;
            mem_addr = {b[7:1], 1'b0};
            we0 = 1'b1;
            d0 = i_mem_rdata[3:0];
            we1 = 1'b1;
            d1 = i_mem_rdata[7:4];
          end else if (op == `LRJD_OP_STP_DIR) begin
            mem_wr = 1'b1;
            mem_pair = 1'b1;
            mem_addr = {b[7:1], 1'b0};
            mem_wdata = {rn[`LRJD_R_EXT], rn[`LRJD_R_ACC]};
          end
        end
      end
      S_WAIT: begin
        next_state = S_OP;
      end
      default: begin
        next_state = S_OP;
      end
    endcase
  end

  assign o_mem_addr = mem_addr;
  assign o_mem_rd = mem_rd;
  assign o_mem_wr = mem_wr;
  assign o_mem_pair = mem_pair;
  assign o_mem_wdata = mem_wdata;

  // --------------------------------------------------------------------
  // Sequencing registers
  // --------------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_OP;
      op <= `LRJD_BYTE_RST;
      op_pc <= `LRJD_PC_RST;
      sup <= 1'b0;
      grp_acc <= 1'b0;
      grp_ptr <= 1'b0;
      o_jump <= 1'b0;
      o_jump_target <= `LRJD_PC_RST;
      o_suppressed <= 1'b0;
    end else begin
      state <= next_state;
      if (state == S_OP && take) begin
        op <= b;
        op_pc <= i_fetch_pc;
      end
      sup <= next_sup;
      grp_acc <= next_grp_acc;
      grp_ptr <= next_grp_ptr;
      o_jump <= next_jump;
      o_suppressed <= next_suppressed;
      if (next_jump) begin
        o_jump_target <= target;
      end
    end
  end

  // --------------------------------------------------------------------
  // Jump target and register file
  // --------------------------------------------------------------------
  lrjd_jump u_jump (
    .i_pc(next_imm_form ? i_fetch_pc : op_pc),
    .i_imm_form(next_imm_form),
    .i_first(b),
    .i_low(next_low),
    .o_target(target)
  );

  lrjd_regfile #(
    .NREG(8)
  ) u_regs (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we0(we0),
    .i_idx0(idx0),
    .i_data0(d0),
    .i_we1(we1),
    .i_idx1(idx1),
    .i_data1(d1),
    .o_flat(o_regs)
  );

endmodule // lrjd_decode

// *** lrjd_decode_props.sv ***
// Port-level checker for the load and relative jump decoder.
// Assumes bind into lrjd_decode; one clock, asynchronous high reset.
`timescale 1ns/100ps

module lrjd_decode_props (
  input wire i_clk,
  input wire i_rst,
  input wire i_fetch_valid,
  input wire [7:0] i_fetch_byte,
  input wire [13:0] i_fetch_pc,
  input wire o_fetch_ready,
  input wire [7:0] o_mem_addr,
  input wire o_mem_rd,
  input wire o_mem_wr,
  input wire o_mem_pair,
  input wire [7:0] o_mem_wdata,
  input wire [7:0] i_mem_rdata,
  input wire o_jump,
  input wire [13:0] o_jump_target,
  input wire o_suppressed,
  input wire [31:0] o_regs
);
  // --------------------------------------------------------------------
  // Instruction boundary tracking
  // --------------------------------------------------------------------
  reg [7:0] op;
  reg second;
  reg [13:0] pc0;
  wire tk = i_fetch_valid && o_fetch_ready;
  wire two = (i_fetch_byte == 8'h8c) || (i_fetch_byte == 8'h89) || (i_fetch_byte == 8'hdd) ||
    (i_fetch_byte == 8'hd9) || (i_fetch_byte == 8'hdc) || (i_fetch_byte == 8'hce) ||
    (i_fetch_byte == 8'hcd) || (i_fetch_byte[7:3] == 5'h10 && i_fetch_byte[0]);
  wire accg = (op[7:4] == 4'hb) || (op == 8'h81);
  wire [13:0] pc2 = pc0 + 14'h0002;
  wire [13:0] sj = i_fetch_byte[4] ? i_fetch_pc + 14'h0001 + {10'h000, i_fetch_byte[3:0]} :
    i_fetch_pc - {10'h000, i_fetch_byte[3:0]};
  wire [3:0] src_nib = o_regs[{i_fetch_byte[2:0], 2'b00} +: 4];

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op <= 8'h00;
      second <= 1'b0;
      pc0 <= 14'h0000;
    end else if (tk) begin
      if (second) begin
        second <= 1'b0;
      end else begin
        second <= two;
        op <= i_fetch_byte;
        pc0 <= i_fetch_pc;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_dir_load: assert property (tk && second && op == 8'h8c |-> o_mem_rd && !o_mem_pair &&
    o_mem_addr == i_fetch_byte) else $error("direct load read wrong");
  a_dir_store: assert property (tk && second && op == 8'h89 |-> o_mem_wr &&
    o_mem_addr == i_fetch_byte && o_mem_wdata == {4'h0, o_regs[3:0]}) else $error("direct store wrong");
  a_ptr_store: assert property (tk && !second && i_fetch_byte == 8'hc4 |-> o_mem_wr &&
    o_mem_addr == o_regs[15:8] && o_mem_wdata[3:0] == o_regs[3:0]) else $error("pointer store wrong");
  a_pair_even: assert property (tk && second && op == 8'hdc && i_fetch_byte == 8'h08 |->
    o_mem_rd && o_mem_pair && o_mem_addr == {o_regs[15:9], 1'b0}) else $error("pair read wrong");
  a_acc_imm: assert property (tk && !second && i_fetch_byte[7:4] == 4'hb && !accg |=>
    o_regs[3:0] == $past(i_fetch_byte[3:0]) && !o_suppressed) else $error("immediate load wrong");
  a_acc_repeat: assert property (tk && !second && i_fetch_byte[7:4] == 4'hb && accg |=>
    o_suppressed && $stable(o_regs)) else $error("repeated load not dropped");
  a_jump_short: assert property (tk && !second && i_fetch_byte[7:5] == 3'h0 &&
    i_fetch_byte != 8'h00 |=> o_jump && !o_fetch_ready && o_jump_target == $past(sj))
    else $error("short jump wrong");
  a_jump_reg: assert property (tk && second && op == 8'hdd && i_fetch_byte == 8'h64 |=>
    o_jump && o_jump_target == {pc2[13:8], o_regs[23:16]}) else $error("register jump wrong");
  a_src_kept: assert property (tk && second && op == 8'hdd && i_fetch_byte[7:3] == 5'h01 |=>
    o_regs[31:4] == $past(o_regs[31:4]) && o_regs[3:0] == $past(src_nib))
    else $error("register move wrong");
  a_wait_one: assert property (o_jump |-> !o_fetch_ready ##1 o_fetch_ready)
    else $error("jump wait cycle wrong");

  c_jump: cover property (o_jump);
  c_drop: cover property (o_suppressed);
  c_pair_wr: cover property (o_mem_wr && o_mem_pair);
endmodule // lrjd_decode_props

bind lrjd_decode lrjd_decode_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_fetch_valid(i_fetch_valid), .i_fetch_byte(i_fetch_byte), .i_fetch_pc(i_fetch_pc),
  .o_fetch_ready(o_fetch_ready), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
  .o_mem_wr(o_mem_wr), .o_mem_pair(o_mem_pair), .o_mem_wdata(o_mem_wdata),
  .i_mem_rdata(i_mem_rdata), .o_jump(o_jump), .o_jump_target(o_jump_target),
  .o_suppressed(o_suppressed), .o_regs(o_regs));

// *** testbench.sv ***
// Self-checking bench for the load and relative jump decoder.
// Assumes combinational data memory read, modelled here as a nibble array.
`timescale 1ns/100ps

module testbench;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg i_fetch_valid = 1'b0;
  reg [7:0] i_fetch_byte = 8'h00;
  reg [13:0] i_fetch_pc = 14'h0000;
  wire o_fetch_ready, o_mem_rd, o_mem_wr, o_mem_pair, o_jump, o_suppressed;
  wire [7:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
  wire [13:0] o_jump_target;
  wire [31:0] o_regs;
  reg [3:0] mem [0:255];
  reg [13:0] pc = 14'h0000;
  integer err_total = 0, num_checks = 0, sup = 0, k;

  lrjd_decode uut (.i_clk(i_clk), .i_rst(i_rst), .i_fetch_valid(i_fetch_valid),
    .i_fetch_byte(i_fetch_byte), .i_fetch_pc(i_fetch_pc), .o_fetch_ready(o_fetch_ready),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_pair(o_mem_pair),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_jump(o_jump),
    .o_jump_target(o_jump_target), .o_suppressed(o_suppressed), .o_regs(o_regs));

  always #4 i_clk = ~i_clk;
  assign i_mem_rdata = o_mem_pair ? {mem[o_mem_addr + 8'h01], mem[o_mem_addr]} :
    {4'h0, mem[o_mem_addr]};
  always @(posedge i_clk) begin
    if (o_mem_wr === 1'b1) begin
      mem[o_mem_addr] <= o_mem_wdata[3:0];
      if (o_mem_pair === 1'b1) mem[o_mem_addr + 8'h01] <= o_mem_wdata[7:4];
    end
    if (o_suppressed === 1'b1) sup = sup + 1;
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  function [3:0] pat(input [7:0] a);
    pat = a[3:0] ^ a[7:4];
  endfunction
  function [3:0] nb(input integer n);
    nb = o_regs[4*n +: 4];
  endfunction
  task chk(input [63:0] seen, input [63:0] exp, input string nm);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Offer one byte and return at the edge that takes it
  task put(input [7:0] x);
    i_fetch_valid <= 1'b1;
    i_fetch_byte <= x;
    i_fetch_pc <= pc;
    @(negedge i_clk);
    while (o_fetch_ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    pc = pc + 14'h0001;
  endtask
  task fin;
    i_fetch_valid <= 1'b0;
    @(negedge i_clk);
  endtask
  task go;
    @(posedge i_clk);
    put(8'h00);
  endtask
  task end_sim;
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_repeat;
    go; put(8'hb1); put(8'h81); put(8'h22); put(8'hb3); fin;
    chk(nb(0), 1, "acc");
    chk(nb(1), 0, "ext");
    go; put(8'h83); put(8'h10); put(8'h83); put(8'h20); put(8'hb3);
    put(8'h85); put(8'h44); put(8'h85); put(8'h55); fin;
    chk({nb(3), nb(2)}, 8'h10, "pointer");
    chk(nb(0), 3, "acc");
    chk({nb(5), nb(4)}, 8'h55, "index");
    chk(sup, 3, "dropped");
  endtask

  task t_mem;
    go; put(8'h83); put(8'h37); put(8'h8c); put(8'h30); fin;
    chk(nb(0), pat(8'h30), "direct load");
    go; put(8'hdc); put(8'h08); fin;
    chk({nb(1), nb(0)}, {pat(8'h37), pat(8'h36)}, "pair load");
    chk({nb(3), nb(2)}, 8'h37, "pointer kept");
    go; put(8'h8d); fin;
    chk(nb(0), pat(8'h37), "indirect");
    go; put(8'h8e); fin;
    chk(nb(0), pat(8'h55), "indirect index");
    go; put(8'h8f); fin;
    chk(nb(0), pat(8'h57), "indirect mixed");
    go; put(8'hce); put(8'h31); fin;
    chk({nb(1), nb(0)}, {pat(8'h31), pat(8'h30)}, "direct pair");
    go; put(8'hb9); put(8'h89); put(8'h40); put(8'hdc); put(8'h00); put(8'hcd); put(8'h42); fin;
    chk(mem[8'h40], 9, "direct store");
    chk({mem[8'h37], mem[8'h36]}, {pat(8'h31), 4'h9}, "pair store");
    chk({mem[8'h43], mem[8'h42]}, {pat(8'h31), 4'h9}, "direct pair store");
    go; put(8'hb6); put(8'hc4); fin;
    chk(mem[8'h37], 6, "pointer store");
  endtask

  task t_regs;
    for (k = 1; k < 8; k = k + 1) begin
      go; put(8'hd9); put({k[3:0], 1'b1, k[2:0]}); put(8'hdd); put({5'h01, k[2:0]}); fin;
      chk(nb(0), k, "reg to acc");
      chk(nb(k), k, "source");
      go; put({4'hb, ~k[3:0]}); put(8'hdd); put({5'h00, k[2:0]}); fin;
      chk(nb(k), {~k[3:0]}, "acc to reg");
    end
    go; put(8'h81); put(8'h5a); put(8'hdc); put(8'hf4); put(8'h87); put(8'h3c);
    put(8'hdc); put(8'hfe); fin;
    chk({nb(5), nb(4)}, 8'h5a, "pair from acc");
    chk({nb(1), nb(0)}, 8'h3c, "acc from pair");
    chk({nb(7), nb(6)}, 8'h3c, "pair source");
  endtask

  task t_jump;
    reg [7:0] tab [0:3];
    tab[0] = 8'h13;
    tab[1] = 8'h1f;
    tab[2] = 8'h0f;
    tab[3] = 8'h10;
    for (k = 0; k < 4; k = k + 1) begin
      go; pc = 14'h0100; put(tab[k]); fin;
      chk(o_jump, 1, "jump");
      chk(o_fetch_ready, 0, "wait");
      chk(o_jump_target, tab[k][4] ? 14'h0101 + tab[k][3:0] : 14'h0100 - tab[k][3:0],
        "short target");
    end
    go; put(8'h85); put(8'hc7); put(8'h81); put(8'he2); pc = 14'h12fe; put(8'hdd); put(8'h64); fin;
    chk(o_jump_target, 14'h13c7, "page end target");
    go; pc = 14'h1240; put(8'hdd); put(8'h60); fin;
    chk(o_jump_target, 14'h12e2, "acc pair target");
  endtask

  initial begin
    for (k = 0; k < 256; k = k + 1) mem[k] = pat(k[7:0]);
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk(o_regs, 0, "reset regs");
    t_repeat;
    t_mem;
    t_regs;
    t_jump;
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    err_total = err_total + 1;
    end_sim;
  end
endmodule // testbench
